// file: design/pwmg_tick_gen.sv
// Purpose: Makes the down-counter decrement strobe
// Assumes: Sources are rate-exact strobes derived from the system clock
// Notes:   Phase accumulators give the exact mean rate with some jitter

`timescale 1ns/10ps

module pwmg_tick_gen
    import pwmg_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  sys_rst,
    pwmg_tick_if.gen   tk
);

    logic [1:0]       srcTick;  // Raw source strobes, fast and slow
    logic [DIV_W-1:0] preCnt;   // Pre-divider position

    // One accumulator per source; a carry past the clock figure is a tick
    genvar i;
    for (i = 0; i < 2; i++) begin : g_src
        localparam logic [ACC_W-1:0] INC = (i == 0) ? ACC_W'(FAST_KHZ) : ACC_W'(SLOW_KHZ);
        localparam logic [ACC_W-1:0] MOD = ACC_W'(CLK_KHZ);
        logic [ACC_W-1:0] acc;      // Fractional phase
        logic [ACC_W-1:0] sum;      // Phase after this cycle
        assign sum = acc + INC;

        // Accumulate; wrap emits one source strobe
        always_ff @(posedge clk) begin
            if (sys_rst || tk.clear) begin
                acc        <= '0;
                srcTick[i] <= 1'b0;
            end else if (sum >= MOD) begin
                acc        <= sum - MOD;
                srcTick[i] <= 1'b1;
            end else begin
                acc        <= sum;
                srcTick[i] <= 1'b0;
            end
        end
    end

    // Select source, then divide by preDiv + 1
    // Compare with >= so a smaller divisor never strands the count
    always_ff @(posedge clk) begin
        if (sys_rst || tk.clear) begin
            preCnt  <= '0;
            tk.tick <= 1'b0;
        end else if (srcTick[tk.clkSel]) begin
            if (preCnt >= tk.preDiv) begin
                preCnt  <= '0;
                tk.tick <= 1'b1;    // Up to 48 MHz strobe
            end else begin
                preCnt  <= preCnt + 1'b1;
                tk.tick <= 1'b0;
            end
        end else begin
            tk.tick <= 1'b0;
        end
    end

endmodule : pwmg_tick_gen

// file: design/pwmg_top.sv
// Purpose: Pulse-width generator with on/off down counter
// Assumes: Count writes and sleep come from logic on the same clock
// Notes:   Count ports show the active values, never the pending ones

`timescale 1ns/10ps

module pwmg_top
    import pwmg_pkg::*;
#(
    parameter int unsigned CW = CNT_W   // Width of both phase counts
)
(
    input  wire logic          clk,           // 250 MHz system clock
    input  wire logic          sys_rst,       // Synchronous, active high
    input  wire logic          sleepReq,      // Sleep from the power unit
    input  wire logic [CFG_W-1:0] pwmConfig,  // Select, invert, divisor
    input  wire logic          cntWrite,      // Count write strobe
    input  wire logic          cntWriteOff,   // 0 = on count, 1 = off count
    input  wire logic [1:0]    cntByteEn,     // Byte lanes of the write
    input  wire logic [CW-1:0] cntWrData,     // Write data
    output logic [CW-1:0]      onPhaseCount,  // Active on count
    output logic [CW-1:0]      offPhaseCount, // Active off count
    output logic               pendingFull,   // All four bytes held
    output logic               pwmOut         // Pulse output pin
);

    // Carrier to the count-clock generator
    pwmg_tick_if tk ();

    pwmg_state_e      state;        // Sequencer state
    pwmg_state_e      next_state;   // Sequencer state, next
    logic [CW-1:0]    downCnt;      // Phase down counter
    logic [CW-1:0]    next_downCnt; // Down counter, next
    logic [CW-1:0]    holdOn;       // Pending on count
    logic [CW-1:0]    holdOff;      // Pending off count
    logic [3:0]       byteFull;     // Which holding bytes are fresh
    logic [3:0]       wrBytes;      // Bytes written this cycle
    logic             fullOn;       // Off count zero: hold high
    logic             fullLow;      // On count zero, off not: hold low
    logic             offEnd;       // Last tick of the off phase
    logic             xfer;         // Holding to active this cycle
    logic             onLevel;      // Logical on/off before invert
    logic [CW-1:0]    loadOn;       // On count used on a reload

    // Configuration fields routed to the tick generator
    assign tk.clkSel = pwmConfig[CFG_SEL_BIT];
    assign tk.preDiv = pwmConfig[CFG_DIV_MSB:CFG_DIV_LSB];
    assign tk.clear  = sleepReq;   // Partial divisions dropped in sleep

    // Count-clock generator
    pwmg_tick_gen u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tk      (tk)
    );

    // Byte lane decode used for both the holding data and the flags
    function automatic logic [3:0] lane_map(
        input logic       wr,
        input logic       isOff,
        input logic [1:0] be
    );
        logic [3:0] m;
        m = 4'h0;
        if (wr) begin
            if (isOff) begin
                m[3:2] = be;
            end else begin
                m[1:0] = be;
            end
        end
        return m;
    endfunction : lane_map

    // Firmware is expected to write both lanes at once
    assign wrBytes = lane_map(cntWrite, cntWriteOff, cntByteEn);

    // Output modes follow the active counts
    assign fullOn  = (offPhaseCount == '0);
    assign fullLow = (onPhaseCount == '0) && !fullOn;

    // Off phase ends when its count is spent on a tick
    assign offEnd = tk.tick && (state == ST_OFF) && (downCnt == '0);

    // Transfer at off end, or at once while held high
    assign xfer = (byteFull == BYTES_ALL) && (offEnd || fullOn) && !sleepReq;

    // A reload at off end uses the new on count when it lands together
    assign loadOn = xfer ? holdOn : onPhaseCount;

    // Bit-wise lane merge, so a narrow count never needs a reversed slice
    function automatic logic [CW-1:0] merge_lanes(
        input logic [CW-1:0] old,
        input logic [CW-1:0] wd,
        input logic [1:0]    be
    );
        logic [CW-1:0] m;
        m = old;
        for (int b = 0; b < CW; b++) begin
            if (be[(b >= 8) ? 1 : 0]) begin
                m[b] = wd[b];
            end
        end
        return m;
    endfunction : merge_lanes

    // Holding registers take every write at any time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            holdOn  <= CW'(ON_RST);
            holdOff <= CW'(OFF_RST);
        end else begin
            holdOn  <= merge_lanes(holdOn, cntWrData, wrBytes[1:0]);
            holdOff <= merge_lanes(holdOff, cntWrData, wrBytes[3:2]);
        end
    end

    // Fresh-byte flags; a write in the transfer cycle stays set
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byteFull <= 4'h0;
        end else if (xfer) begin
            byteFull <= wrBytes;
        end else begin
            byteFull <= byteFull | wrBytes;
        end
    end

    // Status: a complete update is waiting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pendingFull <= 1'b0;
        end else if (xfer) begin
            pendingFull <= (wrBytes == BYTES_ALL);
        end else begin
            pendingFull <= ((byteFull | wrBytes) == BYTES_ALL);
        end
    end

    // Active counts change only by transfer; sleep leaves them
    // Clock setting changes never touch these registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            onPhaseCount  <= CW'(ON_RST);
            offPhaseCount <= CW'(OFF_RST);
        end else if (xfer) begin
            onPhaseCount  <= holdOn;
            offPhaseCount <= holdOff;
        end
    end

    // Sequencer: on phase, then off phase, repeat
    // Each phase spans count + 1 ticks: load tick plus n decrements
    always_comb begin
        next_state   = state;
        next_downCnt = downCnt;
        case (state)
            // First tick starts the on phase
            ST_IDLE: begin
                if (tk.tick) begin
                    next_state   = ST_ON;
                    next_downCnt = onPhaseCount;
                end
            end
            // On phase spent: load the off count
            ST_ON: begin
                if (tk.tick) begin
                    if (downCnt == '0) begin
                        next_state   = ST_OFF;
                        next_downCnt = offPhaseCount;
                    end else begin
                        next_downCnt = downCnt - 1'b1;
                    end
                end
            end
            // Off phase spent: period over, reload on count
            ST_OFF: begin
                if (tk.tick) begin
                    if (downCnt == '0) begin
                        next_state   = ST_ON;
                        next_downCnt = loadOn;
                    end else begin
                        next_downCnt = downCnt - 1'b1;
                    end
                end
            end
            // Illegal code: fall back to the idle state
            default: begin
                next_state   = ST_IDLE;
                next_downCnt = '0;
            end
        endcase
    end

    // State and counter; sleep forces idle and zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state   <= ST_IDLE;
            downCnt <= '0;
        end else if (sleepReq) begin
            state   <= ST_IDLE;
            downCnt <= '0;
        end else begin
            state   <= next_state;
            downCnt <= next_downCnt;
        end
    end

    // Logical level: held modes override the phase
    // Duty is (on+1)/(on+1+off+1) from the phase lengths
    always_comb begin
        if (sleepReq) begin
            onLevel = 1'b0;
        end else if (fullOn) begin
            onLevel = 1'b1;
        end else if (fullLow) begin
            onLevel = 1'b0;
        end else begin
            onLevel = (state == ST_ON);
        end
    end

    // Pin driven from a flop; invert turns on into low
    // No interrupt path exists in this block
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwmOut <= 1'b0;
        end else begin
            pwmOut <= onLevel ^ pwmConfig[CFG_INV_BIT];
        end
    end

endmodule : pwmg_top

// file: include/pwmg_pkg.sv
// Purpose: Shared constants and types of the pulse-width generator
// Assumes: One 250 MHz system clock; both count sources made from it
// Notes:   Counts are in kHz so every rate divides out exactly

package pwmg_pkg;

    // System clock and the two counter sources, in kHz
    localparam int unsigned CLK_KHZ  = 250000;  // 250 MHz system clock
    localparam int unsigned FAST_KHZ = 48000;   // Fast source, 48 MHz
    localparam int unsigned SLOW_KHZ = 100;     // Slow source, 100 kHz

    // Phase accumulator width; must hold twice the clock figure
    localparam int unsigned ACC_W = 19;

    // Configuration word layout
    localparam int unsigned CFG_W        = 7;   // Bits 6:1 in use, bit 0 spare
    localparam int unsigned CFG_SEL_BIT  = 1;   // Source select, 1 = slow
    localparam int unsigned CFG_INV_BIT  = 2;   // Invert the on level
    localparam int unsigned CFG_DIV_LSB  = 3;   // Pre-divider low bit
    localparam int unsigned CFG_DIV_MSB  = 6;   // Pre-divider high bit
    localparam int unsigned DIV_W        = 4;   // Pre-divider width

    // Count widths and values after reset
    localparam int unsigned CNT_W       = 16;
    localparam logic [15:0] ON_RST      = 16'h0000;
    localparam logic [15:0] OFF_RST     = 16'hFFFF;
    localparam int unsigned BYTE_CNT    = 4;    // Bytes in one full update
    localparam logic [3:0]  BYTES_ALL   = 4'hF; // Every byte written

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,   // Reset or sleep, output off
        ST_ON   = 3'b010,   // Counting the on phase
        ST_OFF  = 3'b100    // Counting the off phase
    } pwmg_state_e;

endpackage : pwmg_pkg

// file: include/pwmg_tick_if.sv
// Purpose: Carrier between the sequencer and its count-clock generator
// Assumes: Both ends run on the same system clock
// Notes:   Tick is a one-cycle pulse at the divided count rate

`timescale 1ns/10ps

interface pwmg_tick_if;
    import pwmg_pkg::*;

    logic             clkSel;   // 0 = fast source, 1 = slow source
    logic [DIV_W-1:0] preDiv;   // Divide by preDiv + 1
    logic             clear;    // Sleep: drop all partial counts
    logic             tick;     // One pulse per divided period

    modport gen (
        input  clkSel,
        input  preDiv,
        input  clear,
        output tick
    );

    modport ctl (
        output clkSel,
        output preDiv,
        output clear,
        input  tick
    );

endinterface : pwmg_tick_if

// file: tb/pwmg_bench.sv
// Purpose: Self-checking bench for the pulse-width generator
// Assumes: Counts narrowed to 8 bits so the reset off phase is short
// Notes:   Level times are judged within a few cycles of source jitter

`timescale 1ns/10ps

module pwmg_bench
    import pwmg_pkg::*;
;
    localparam int K = 2;      // Periods timed per row
    localparam int W = 8;      // Narrow count width
    typedef struct {
        logic         sel;
        logic         inv;
        logic [3:0]   div;
        logic [W-1:0] on;
        logic [W-1:0] off;
        int           hiT;     // Source ticks high per period
        int           loT;     // Source ticks low per period
    } pwmg_row_s;
    // Toggling cases with ticks worked out from the count equations
    pwmg_row_s rows [4] = '{
        '{1'b0, 1'b0, 4'h0, 8'h01, 8'h02, 2, 3},
        '{1'b0, 1'b1, 4'h1, 8'h04, 8'h01, 4, 10},
        '{1'b0, 1'b0, 4'hF, 8'h01, 8'h01, 32, 32},
        '{1'b1, 1'b0, 4'h0, 8'h01, 8'h01, 2, 2}};
    logic             clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             sleepReq = 1'b0;
    logic [CFG_W-1:0] pwmConfig = '0;
    logic             cntWrite = 1'b0;
    logic             cntWriteOff = 1'b0;
    logic [1:0]       cntByteEn = 2'h3;
    logic [W-1:0]     cntWrData = '0;
    logic [W-1:0]     onPhaseCount;
    logic [W-1:0]     offPhaseCount;
    logic             pendingFull;
    logic             pwmOut;
    logic             clear = 1'b0;
    int               hiCnt;
    int               loCnt;
    int               edges;
    int               n_mismatch = 0;
    int               checked = 0;

    always #2 clk = ~clk;

    pwmg_top #(.CW(W)) pwmg_top_inst (.clk, .sys_rst, .sleepReq, .pwmConfig, .cntWrite,
        .cntWriteOff, .cntByteEn, .cntWrData, .onPhaseCount, .offPhaseCount, .pendingFull,
        .pwmOut);
    pwmg_load_model pwmg_load_model_inst (.clk, .pwmOut, .clear, .hiCnt, .loCnt, .edges);

    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // Inputs always move 1 ns after the edge
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic checkVal(string nm, logic [W-1:0] seen, logic [W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : checkVal

    // Source strobes jitter by a cycle, so allow a small margin
    task automatic checkCyc(string nm, int seen, int ticks, int src);
        longint expc;
        expc = longint'(K * ticks) * CLK_KHZ / src;
        checked++;
        if (seen > expc + 6 || seen + 6 < expc) begin
            n_mismatch++;
            $display("ERROR %s expected %0d seen %0d", nm, expc, seen);
        end
    endtask : checkCyc

    // On word then off word, back to back, on the lanes set in cntByteEn
    task automatic writeCounts(logic [W-1:0] on, logic [W-1:0] off);
        cntWrite = 1'b1;
        cntWriteOff = 1'b0;
        cntWrData = on;
        step(1);
        cntWriteOff = 1'b1;
        cntWrData = off;
        step(1);
        cntWrite = 1'b0;
    endtask : writeCounts

    // Bounded wait for the holding registers to empty
    task automatic waitXfer();
        int i = 0;
        while (pendingFull !== 1'b0 && i < 30000) begin
            step(1);
            i++;
        end
        checkVal("pendingFull", W'(pendingFull), '0);
        if (i >= 30000) finish_test();
    endtask : waitXfer

    task automatic holdCheck(logic lvl, int n);
        int bad = 0;
        repeat (n) begin
            step(1);
            bad += int'(pwmOut !== lvl);
        end
        checkVal("holdMiss", W'(bad != 0), '0);
    endtask : holdCheck

    initial begin
        int i;
        step(20);
        sys_rst = 1'b0;
        checkVal("onPhaseCount", onPhaseCount, '0);
        checkVal("offPhaseCount", offPhaseCount, '1);
        checkVal("pwmOut", W'(pwmOut), '0);
        foreach (rows[r]) begin
            pwmConfig = {rows[r].div, rows[r].inv, rows[r].sel, 1'b0};
            writeCounts(rows[r].on, rows[r].off);
            step(1);
            checkVal("pendingFull", W'(pendingFull), 8'h01);
            waitXfer();
            checkVal("onPhaseCount", onPhaseCount, rows[r].on);
            checkVal("offPhaseCount", offPhaseCount, rows[r].off);
            clear = 1'b1;
            step(1);
            clear = 1'b0;
            i = 0;
            while (edges < K + 1 && i < 30000) begin
                step(1);
                i++;
            end
            if (i >= 30000) n_mismatch++;
            if (i >= 30000) finish_test();
            checkCyc("highCycles", hiCnt, rows[r].hiT, rows[r].sel ? SLOW_KHZ : FAST_KHZ);
            checkCyc("lowCycles", loCnt, rows[r].loT, rows[r].sel ? SLOW_KHZ : FAST_KHZ);
        end
        writeCounts(8'h05, 8'h00);
        step(1);
        waitXfer();
        holdCheck(1'b1, 300);
        writeCounts(8'h00, 8'h03);
        step(2);
        checkVal("offPhaseCount", offPhaseCount, 8'h03);
        checkVal("pendingFull", W'(pendingFull), '0);
        holdCheck(1'b0, 300);
        pwmConfig = 7'h04;
        sleepReq = 1'b1;
        step(3);
        checkVal("pwmOut", W'(pwmOut), 8'h01);
        cntByteEn = 2'h1;
        writeCounts(8'h07, 8'h07);
        step(2);
        checkVal("pendingFull", W'(pendingFull), '0);
        checkVal("offPhaseCount", offPhaseCount, 8'h03);
        sleepReq = 1'b0;
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        checkVal("offPhaseCount", offPhaseCount, '1);
        finish_test();
    end
endmodule : pwmg_bench

// file: tb/pwmg_load_model.sv
// Purpose: Load on the pulse pin, timing its high and low levels
// Assumes: Pin sampled on the system clock
// Notes:   Timing starts at the first rising level after clear

`timescale 1ns/10ps

module pwmg_load_model (
    input  wire logic clk,
    input  wire logic pwmOut,
    input  wire logic clear,
    output int        hiCnt,
    output int        loCnt,
    output int        edges
);
    logic prev = 1'b0;  // Level at the previous edge

    // Count rising levels; time only whole periods after the first rise
    always_ff @(posedge clk) begin
        prev <= pwmOut;
        if (clear) begin
            edges <= 0;
            hiCnt <= 0;
            loCnt <= 0;
        end else begin
            if (pwmOut && !prev) begin
                edges <= edges + 1;
            end
            if (edges != 0) begin
                hiCnt <= hiCnt + int'(pwmOut);
                loCnt <= loCnt + int'(!pwmOut);
            end
        end
    end
endmodule : pwmg_load_model

// file: tb/pwmg_top_checker.sv
// Purpose: Port assertions for the pulse-width generator
// Assumes: One clock, synchronous active-high reset
// Notes:   Output is registered, so level checks allow a settling cycle

`timescale 1ns/10ps

module pwmg_top_checker
    import pwmg_pkg::*;
#(
    parameter int unsigned CW = CNT_W
)
(
    input wire logic             clk,
    input wire logic             sys_rst,
    input wire logic             sleepReq,
    input wire logic [CFG_W-1:0] pwmConfig,
    input wire logic             cntWrite,
    input wire logic             cntWriteOff,
    input wire logic [1:0]       cntByteEn,
    input wire logic [CW-1:0]    cntWrData,
    input wire logic [CW-1:0]    onPhaseCount,
    input wire logic [CW-1:0]    offPhaseCount,
    input wire logic             pendingFull,
    input wire logic             pwmOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_reset;
        disable iff (1'b0) sys_rst |=> onPhaseCount == '0 && offPhaseCount == '1 && !pendingFull;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");
    property p_sleep;
        (sleepReq && $stable(pwmConfig)) [*2] |-> pwmOut == pwmConfig[CFG_INV_BIT];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep level wrong");
    property p_hold;
        !pendingFull |=> $stable(onPhaseCount) && $stable(offPhaseCount);
    endproperty
    a_hold: assert property (p_hold) else $error("counts moved unheld");
    property p_empty;
        !pendingFull && !cntWrite |=> !pendingFull;
    endproperty
    a_empty: assert property (p_empty) else $error("holding full unwritten");
    property p_four;
        !pendingFull && cntWrite && !cntWriteOff && cntByteEn == 2'h3 ##1
        !pendingFull && cntWrite && cntWriteOff && cntByteEn == 2'h3 |=> pendingFull;
    endproperty
    a_four: assert property (p_four) else $error("holding not full");
    property p_fullOn;
        pendingFull && offPhaseCount == '0 && !sleepReq |=> !pendingFull;
    endproperty
    a_fullOn: assert property (p_fullOn) else $error("full on not immediate");
    property p_fullOff;
        (onPhaseCount == '0 && offPhaseCount != '0 && $stable(offPhaseCount)
         && $stable(pwmConfig)) [*3] |-> pwmOut == pwmConfig[CFG_INV_BIT];
    endproperty
    a_fullOff: assert property (p_fullOff) else $error("full off not held");
    property p_cfg;
        !pendingFull && $changed(pwmConfig) |=> $stable(onPhaseCount) && $stable(offPhaseCount);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config moved counts");
    property p_fullHigh;
        (offPhaseCount == '0 && !sleepReq && $stable(pwmConfig)) [*2]
        |-> pwmOut != pwmConfig[CFG_INV_BIT];
    endproperty
    a_fullHigh: assert property (p_fullHigh) else $error("full on not held");
endmodule : pwmg_top_checker

bind pwmg_top pwmg_top_checker #(.CW(CW)) pwmg_top_checker_inst (.clk, .sys_rst, .sleepReq,
    .pwmConfig, .cntWrite, .cntWriteOff, .cntByteEn, .cntWrData, .onPhaseCount,
    .offPhaseCount, .pendingFull, .pwmOut);
